// [common/pmd_defs.svh]
// Offsets, masks, reset values and memory-map addresses of the port block
`ifndef PMD_DEFS_SVH
`define PMD_DEFS_SVH

// Register indices; byte address is four times the index
`define PMD_IDX_PORT_A_DATA 6'h00
`define PMD_IDX_PORT_B_DATA 6'h01
`define PMD_IDX_PORT_C_DATA 6'h02
`define PMD_IDX_PORT_D_DATA 6'h03
`define PMD_IDX_PORT_A_DIR 6'h04
`define PMD_IDX_PORT_B_DIR 6'h05
`define PMD_IDX_PORT_C_DIR 6'h06
`define PMD_IDX_PORT_D_DIR 6'h07
`define PMD_IDX_LAST 6'h07

// Implemented bits per register
`define PMD_MASK_A_DATA 8'hFF
`define PMD_MASK_B_DATA 8'hE0
`define PMD_MASK_C_DATA 8'hFF
`define PMD_MASK_D_DATA 8'hA0
`define PMD_MASK_A_DIR 8'hFF
`define PMD_MASK_B_DIR 8'hE0
`define PMD_MASK_C_DIR 8'hFF
`define PMD_MASK_D_DIR 8'h20
// Port D bit 4 always reads one
`define PMD_ONES_D_DATA 8'h10

// Direction reset value
`define PMD_DIR_RESET 8'h00

// Memory map
`define PMD_IO_FIRST 13'h0000
`define PMD_IO_LAST 13'h001F
`define PMD_PAGE0_ROM_FIRST 13'h0020
`define PMD_PAGE0_ROM_LAST 13'h004F
`define PMD_VEC_ROM_FIRST 13'h1FF8
`define PMD_VEC_ROM_LAST 13'h1FFF
`define PMD_VEC_TIMER_HIGH 13'h1FF8
`define PMD_VEC_TIMER_LOW 13'h1FF9
`define PMD_VEC_EXT_HIGH 13'h1FFA
`define PMD_VEC_EXT_LOW 13'h1FFB
`define PMD_VEC_SWI_HIGH 13'h1FFC
`define PMD_VEC_SWI_LOW 13'h1FFD
`define PMD_VEC_RESET_HIGH 13'h1FFE
`define PMD_VEC_RESET_LOW 13'h1FFF

`endif

// [common/pmd_pkg.sv]
// Types shared by the port and map decode block
package pmd_pkg;

	typedef enum logic [3:0] {
		PMD_ST_IDLE = 4'h1,
		PMD_ST_HIGH = 4'h2,
		PMD_ST_LOW = 4'h4,
		PMD_ST_DONE = 4'h8
	} pmd_vec_state_t;

	typedef enum logic [1:0] {
		PMD_VEC_TIMER = 2'h0,
		PMD_VEC_EXT = 2'h1,
		PMD_VEC_SWI = 2'h2,
		PMD_VEC_RESET = 2'h3
	} pmd_vec_src_t;

endpackage

// [design/pmd_port_map.sv]
// Port registers, pin control, memory-map decode and vector fetch
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "pmd_defs.svh"

module pmd_port_map (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port pins
	input wire logic [7:0] pin_a_in,
	output logic [7:0] pin_a_out,
	output logic [7:0] pin_a_oe,
	input wire logic [7:0] pin_b_in,
	output logic [7:0] pin_b_out,
	output logic [7:0] pin_b_oe,
	input wire logic [7:0] pin_c_in,
	output logic [7:0] pin_c_out,
	output logic [7:0] pin_c_oe,
	input wire logic [7:0] pin_d_in,
	output logic [7:0] pin_d_out,
	output logic [7:0] pin_d_oe,
	// Memory-map decode
	input wire logic [12:0] map_addr,
	output logic sel_io,
	output logic sel_page0_rom,
	output logic sel_vec_rom,
	output logic sel_reset_vec,
	// Vector fetch
	input wire logic vec_req,
	input wire logic [1:0] vec_src,
	output logic vec_rom_en,
	output logic [12:0] vec_rom_addr,
	input wire logic [7:0] vec_rom_data,
	output logic vec_valid,
	output logic [15:0] vec_value
);

	logic [7:0] port_a_data;
	logic [7:0] port_b_data;
	logic [7:0] port_c_data;
	logic [7:0] port_d_data;
	logic [7:0] port_a_dir;
	logic [7:0] port_b_dir;
	logic [7:0] port_c_dir;
	logic [7:0] port_d_dir;
	logic [5:0] reg_idx;
	logic addr_hit;
	logic setup_phase;
	logic wr_en;
	logic [7:0] wbyte;
	logic [7:0] next_rdata;
	pmd_pkg::pmd_vec_state_t vec_state;
	pmd_pkg::pmd_vec_state_t next_vec_state;
	logic [12:0] vec_high_addr;
	logic [7:0] vec_high_byte;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	assign reg_idx = paddr[7:2];
	assign addr_hit = (paddr[1:0] == 2'h0) && (reg_idx <= `PMD_IDX_LAST);
	assign setup_phase = psel && !penable;
	// Write lands at the access edge that samples pready high
	assign wr_en = ce && psel && penable && pready && pwrite && addr_hit
		&& pstrb[0];
	assign wbyte = pwdata[7:0];

	// Read value: latch where driven, pin where input
	function automatic logic [7:0] port_view(input logic [7:0] dat,
		input logic [7:0] dir, input logic [7:0] pin,
		input logic [7:0] mask);
		port_view = ((dir & dat) | (~dir & pin)) & mask;
	endfunction

	always_comb begin
		next_rdata = 8'h00;
		case (reg_idx)
		`PMD_IDX_PORT_A_DATA: begin
			next_rdata = port_view(port_a_data, port_a_dir, pin_a_in,
				`PMD_MASK_A_DATA);
		end
		`PMD_IDX_PORT_B_DATA: begin
			next_rdata = port_view(port_b_data, port_b_dir, pin_b_in,
				`PMD_MASK_B_DATA);
		end
		`PMD_IDX_PORT_C_DATA: begin
			next_rdata = port_view(port_c_data, port_c_dir, pin_c_in,
				`PMD_MASK_C_DATA);
		end
		`PMD_IDX_PORT_D_DATA: begin
			next_rdata = port_view(port_d_data, port_d_dir, pin_d_in,
				`PMD_MASK_D_DATA) | `PMD_ONES_D_DATA;
		end
		`PMD_IDX_PORT_A_DIR: begin
			next_rdata = port_a_dir;
		end
		`PMD_IDX_PORT_B_DIR: begin
			next_rdata = port_b_dir;
		end
		`PMD_IDX_PORT_C_DIR: begin
			next_rdata = port_c_dir;
		end
		`PMD_IDX_PORT_D_DIR: begin
			next_rdata = port_d_dir;
		end
		default: begin
			next_rdata = 8'h00;
		end
		endcase
		if (!addr_hit) begin
			next_rdata = 8'h00;
		end
	end

	// APB answer: one access cycle, no wait states
	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (ce) begin
			pready <= setup_phase;
			pslverr <= setup_phase && !addr_hit;
			if (setup_phase && !pwrite) begin
				prdata <= {24'h000000, next_rdata};
			end
		end
	end

	// Data latches keep their contents through reset
	always_ff @(posedge clk) begin
		if (wr_en) begin
			case (reg_idx)
			`PMD_IDX_PORT_A_DATA: begin
				port_a_data <= wbyte & `PMD_MASK_A_DATA;
			end
			`PMD_IDX_PORT_B_DATA: begin
				port_b_data <= wbyte & `PMD_MASK_B_DATA;
			end
			`PMD_IDX_PORT_C_DATA: begin
				port_c_data <= wbyte & `PMD_MASK_C_DATA;
			end
			`PMD_IDX_PORT_D_DATA: begin
				port_d_data <= wbyte & `PMD_MASK_D_DATA;
			end
			default: begin
			end
			endcase
		end
	end

	// Direction registers clear on reset
	always_ff @(posedge clk) begin
		if (rst) begin
			port_a_dir <= `PMD_DIR_RESET;
			port_b_dir <= `PMD_DIR_RESET;
			port_c_dir <= `PMD_DIR_RESET;
			port_d_dir <= `PMD_DIR_RESET;
		end else if (wr_en) begin
			case (reg_idx)
			`PMD_IDX_PORT_A_DIR: begin
				port_a_dir <= wbyte & `PMD_MASK_A_DIR;
			end
			`PMD_IDX_PORT_B_DIR: begin
				port_b_dir <= wbyte & `PMD_MASK_B_DIR;
			end
			`PMD_IDX_PORT_C_DIR: begin
				port_c_dir <= wbyte & `PMD_MASK_C_DIR;
			end
			`PMD_IDX_PORT_D_DIR: begin
				port_d_dir <= wbyte & `PMD_MASK_D_DIR;
			end
			default: begin
			end
			endcase
		end
	end

	// Pin drivers; latch value gated so outputs are defined after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_a_out <= 8'h00;
			pin_b_out <= 8'h00;
			pin_c_out <= 8'h00;
			pin_d_out <= 8'h00;
			pin_a_oe <= 8'h00;
			pin_b_oe <= 8'h00;
			pin_c_oe <= 8'h00;
			pin_d_oe <= 8'h00;
		end else if (ce) begin
			pin_a_out <= port_a_data & port_a_dir;
			pin_b_out <= port_b_data & port_b_dir;
			pin_c_out <= port_c_data & port_c_dir;
			pin_d_out <= port_d_data & port_d_dir;
			pin_a_oe <= port_a_dir;
			pin_b_oe <= port_b_dir;
			pin_c_oe <= port_c_dir;
			pin_d_oe <= port_d_dir;
		end
	end

	// Memory-map decode
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_io <= 1'b0;
			sel_page0_rom <= 1'b0;
			sel_vec_rom <= 1'b0;
			sel_reset_vec <= 1'b0;
		end else if (ce) begin
			sel_io <= (map_addr <= `PMD_IO_LAST);
			sel_page0_rom <= (map_addr >= `PMD_PAGE0_ROM_FIRST)
				&& (map_addr <= `PMD_PAGE0_ROM_LAST);
			sel_vec_rom <= map_addr >= `PMD_VEC_ROM_FIRST;
			sel_reset_vec <= map_addr >= `PMD_VEC_RESET_HIGH;
		end
	end

	// Vector high-byte address per source
	always_comb begin
		case (pmd_pkg::pmd_vec_src_t'(vec_src))
		pmd_pkg::PMD_VEC_TIMER: vec_high_addr = `PMD_VEC_TIMER_HIGH;
		pmd_pkg::PMD_VEC_EXT: vec_high_addr = `PMD_VEC_EXT_HIGH;
		pmd_pkg::PMD_VEC_SWI: vec_high_addr = `PMD_VEC_SWI_HIGH;
		pmd_pkg::PMD_VEC_RESET: vec_high_addr = `PMD_VEC_RESET_HIGH;
		default: vec_high_addr = `PMD_VEC_RESET_HIGH;
		endcase
	end

	always_comb begin
		case (vec_state)
		pmd_pkg::PMD_ST_IDLE: begin
			next_vec_state = vec_req ? pmd_pkg::PMD_ST_HIGH
				: pmd_pkg::PMD_ST_IDLE;
		end
		pmd_pkg::PMD_ST_HIGH: next_vec_state = pmd_pkg::PMD_ST_LOW;
		pmd_pkg::PMD_ST_LOW: next_vec_state = pmd_pkg::PMD_ST_DONE;
		pmd_pkg::PMD_ST_DONE: next_vec_state = pmd_pkg::PMD_ST_IDLE;
		default: next_vec_state = pmd_pkg::PMD_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			vec_state <= pmd_pkg::PMD_ST_IDLE;
		end else if (ce) begin
			vec_state <= next_vec_state;
		end
	end

	// Fetch high byte first, then the byte after it
	always_ff @(posedge clk) begin
		if (rst) begin
			vec_rom_en <= 1'b0;
			vec_rom_addr <= 13'h0000;
			vec_high_byte <= 8'h00;
			vec_valid <= 1'b0;
			vec_value <= 16'h0000;
		end else if (ce) begin
			vec_valid <= 1'b0;
			vec_rom_en <= 1'b0;
			case (vec_state)
			pmd_pkg::PMD_ST_IDLE: begin
				if (vec_req) begin
					vec_rom_en <= 1'b1;
					vec_rom_addr <= vec_high_addr;
				end
			end
			pmd_pkg::PMD_ST_HIGH: begin
				vec_rom_en <= 1'b1;
				vec_rom_addr <= vec_rom_addr + 13'h0001;
			end
			pmd_pkg::PMD_ST_LOW: begin
				vec_high_byte <= vec_rom_data;
			end
			pmd_pkg::PMD_ST_DONE: begin
				vec_valid <= 1'b1;
				vec_value <= {vec_high_byte, vec_rom_data};
			end
			default: begin
			end
			endcase
		end
	end

	property p_page0_decode;
		ce && map_addr >= 13'h0020 && map_addr <= 13'h004F
			|=> sel_page0_rom;
	endproperty
	a_page0_decode: assert property (p_page0_decode)
		else $error("page-zero rom not selected");

	property p_reset_vec_decode;
		ce && map_addr == 13'h1FFE |=> sel_reset_vec && sel_vec_rom;
	endproperty
	a_reset_vec_decode: assert property (p_reset_vec_decode)
		else $error("reset vector slot not selected");

	property p_timer_vec;
		vec_state == pmd_pkg::PMD_ST_IDLE && ce && vec_req && vec_src == 2'h0
			##1 ce |-> vec_rom_addr == 13'h1FF8 ##1
			vec_rom_addr == 13'h1FF9;
	endproperty
	a_timer_vec: assert property (p_timer_vec)
		else $error("timer vector address order wrong");

	property p_ext_vec;
		vec_state == pmd_pkg::PMD_ST_IDLE && ce && vec_req && vec_src == 2'h1
			##1 ce |=> vec_rom_addr == 13'h1FFB
			&& $past(vec_rom_addr) == 13'h1FFA;
	endproperty
	a_ext_vec: assert property (p_ext_vec)
		else $error("external vector address order wrong");

	property p_swi_value;
		vec_state == pmd_pkg::PMD_ST_LOW && ce ##1 ce |=>
			vec_valid && vec_value[15:8] == $past(vec_rom_data, 2);
	endproperty
	a_swi_value: assert property (p_swi_value)
		else $error("vector high byte not from first fetch");

	property p_b_read_zero;
		pready && !pwrite && paddr == 8'h04 |-> prdata[4:0] == 5'h00;
	endproperty
	a_b_read_zero: assert property (p_b_read_zero)
		else $error("port b low bits not zero");

	property p_d_read_one;
		pready && !pwrite && paddr == 8'h0C |->
			prdata[4] == 1'b1 && prdata[6] == 1'b0 && prdata[3:0] == 4'h0;
	endproperty
	a_d_read_one: assert property (p_d_read_one)
		else $error("port d fixed bits wrong");

	property p_dir_reset;
		$past(rst) |-> port_a_dir == 8'h00 && port_b_dir == 8'h00
			&& port_c_dir == 8'h00 && port_d_dir == 8'h00;
	endproperty
	a_dir_reset: assert property (p_dir_reset)
		else $error("direction register not cleared");

	property p_d_dir_bits;
		port_d_dir[7:6] == 2'h0 && port_d_dir[4:0] == 5'h00;
	endproperty
	a_d_dir_bits: assert property (p_d_dir_bits)
		else $error("port d direction extra bit set");

	property p_oe_follows_dir;
		ce |=> pin_c_oe == $past(port_c_dir) && pin_a_oe == $past(port_a_dir);
	endproperty
	a_oe_follows_dir: assert property (p_oe_follows_dir)
		else $error("pin enable does not follow direction");

	property p_read_source;
		ce && setup_phase && !pwrite && paddr == 8'h08 |=>
			prdata[7:0] == (($past(port_c_dir) & $past(port_c_data))
			| (~$past(port_c_dir) & $past(pin_c_in)));
	endproperty
	a_read_source: assert property (p_read_source)
		else $error("read does not pick latch or pin by direction");

	property p_a_write_kept;
		disable iff (1'b0)
		wr_en && paddr == 8'h00 ##2 rst |=> port_a_data == $past(wbyte, 3);
	endproperty
	a_a_write_kept: assert property (p_a_write_kept)
		else $error("port a data lost through reset");

endmodule

// [bench/pmd_pin_model.sv]
// Outside circuitry on one eight-bit port
`timescale 1ns/1ps
module pmd_pin_model (
	// Device side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// Outside drive
	input wire logic [7:0] ext,
	output logic [7:0] pin_in
);
	// Outside level only where the device lets go
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// [bench/testbench.sv]
// Self-checking bench for the port and map decode block
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, rerr;
	logic [7:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
	logic [7:0] c_in, c_out, c_oe, d_in, d_out, d_oe;
	logic [7:0] ext_a = 8'h00, ext_b = 8'h00, ext_c = 8'h00, ext_d = 8'h00;
	logic [12:0] map_addr = 13'h0000, vec_rom_addr;
	logic sel_io, sel_p0, sel_vec, sel_rv, vec_req = 0, vec_rom_en, vec_valid;
	logic [1:0] vec_src = 2'h0;
	logic [7:0] vec_rom_data = 8'h00;
	logic [15:0] vec_value;
	int err_total = 0, checks = 0, cyc = 0;

	always #12.5 clk = ~clk;

	pmd_port_map dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_a_in(a_in), .pin_a_out(a_out), .pin_a_oe(a_oe),
		.pin_b_in(b_in), .pin_b_out(b_out), .pin_b_oe(b_oe),
		.pin_c_in(c_in), .pin_c_out(c_out), .pin_c_oe(c_oe),
		.pin_d_in(d_in), .pin_d_out(d_out), .pin_d_oe(d_oe),
		.map_addr(map_addr), .sel_io(sel_io), .sel_page0_rom(sel_p0),
		.sel_vec_rom(sel_vec), .sel_reset_vec(sel_rv), .vec_req(vec_req),
		.vec_src(vec_src), .vec_rom_en(vec_rom_en),
		.vec_rom_addr(vec_rom_addr), .vec_rom_data(vec_rom_data),
		.vec_valid(vec_valid), .vec_value(vec_value));
	pmd_pin_model pa (.pin_out(a_out), .pin_oe(a_oe), .ext(ext_a),
		.pin_in(a_in));
	pmd_pin_model pb (.pin_out(b_out), .pin_oe(b_oe), .ext(ext_b),
		.pin_in(b_in));
	pmd_pin_model pc (.pin_out(c_out), .pin_oe(c_oe), .ext(ext_c),
		.pin_in(c_in));
	pmd_pin_model pd (.pin_out(d_out), .pin_oe(d_oe), .ext(ext_d),
		.pin_in(d_in));

	// Vector ROM: valid the cycle after its strobe, scrambled otherwise
	always_ff @(posedge clk) begin
		if (vec_rom_en)
			vec_rom_data <= vec_rom_addr[7:0] ^ 8'h5A;
		else
			vec_rom_data <= ~vec_rom_data;
	end

	task close_out;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out;
		end
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task do_rst;
		@(posedge clk);
		rst <= 1;
		repeat (16) @(posedge clk);
		rst <= 0;
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task wr(input logic [5:0] i, input logic [7:0] d);
		apb(1, {i, 2'b00}, d, 4'hF);
	endtask

	task rd(input logic [5:0] i, input logic [7:0] e);
		apb(0, {i, 2'b00}, 8'h00, 4'hF);
		chk("prdata", {24'h0, e}, rdat);
		chk("pslverr", 0, rerr);
	endtask

	task t_reset_dirs;
		for (int i = 4; i < 8; i++)
			rd(6'(i), 8'h00);
		chk("oe", 0, {a_oe, b_oe, c_oe, d_oe});
	endtask

	task t_out_mode;
		logic [7:0] ex [8];
		ex = '{8'hFF, 8'hE0, 8'hFF, 8'h30, 8'hFF, 8'hE0, 8'hFF, 8'h20};
		for (int i = 0; i < 8; i++)
			wr(6'(i), 8'hFF);
		for (int i = 0; i < 4; i++)
			rd(6'(i), ex[i]);
		for (int i = 4; i < 8; i++)
			rd(6'(i), ex[i]);
		repeat (2) @(posedge clk);
		chk("oe", 32'hFFE0FF20, {a_oe, b_oe, c_oe, d_oe});
		chk("out", 32'hFFE0FF20, {a_out, b_out, c_out, d_out});
	endtask

	task t_in_mode;
		logic [7:0] ex [4];
		ex = '{8'hA5, 8'hA0, 8'hA5, 8'hB0};
		for (int i = 4; i < 8; i++)
			wr(6'(i), 8'h00);
		ext_a <= 8'hA5;
		ext_b <= 8'hA5;
		ext_c <= 8'hA5;
		ext_d <= 8'hA5;
		for (int i = 0; i < 4; i++)
			rd(6'(i), ex[i]);
		chk("oe", 0, {a_oe, b_oe, c_oe, d_oe});
	endtask

	task t_keep;
		logic [7:0] ex [4];
		ex = '{8'h3C, 8'hA0, 8'hC3, 8'h30};
		ext_d <= 8'h00;
		for (int i = 4; i < 8; i++)
			wr(6'(i), 8'hFF);
		wr(1, 8'hA0);
		wr(2, 8'hC3);
		wr(3, 8'hFF);
		// Port A last, so reset follows its write closely
		wr(0, 8'h3C);
		do_rst;
		t_reset_dirs;
		for (int i = 4; i < 8; i++)
			wr(6'(i), 8'hFF);
		for (int i = 0; i < 4; i++)
			rd(6'(i), ex[i]);
	endtask

	task t_refuse;
		apb(0, 8'h20, 8'h00, 4'hF);
		chk("unmapped err", 1, rerr);
		chk("unmapped data", 0, rdat);
		apb(1, 8'h11, 8'h00, 4'hF);
		chk("misaligned err", 1, rerr);
		apb(1, 8'h10, 8'h00, 4'h0);
		chk("strobe err", 0, rerr);
		rd(4, 8'hFF);
	endtask

	task t_decode;
		logic [12:0] ad [10];
		logic [3:0] ex [10];
		ad = '{13'h0000, 13'h001F, 13'h0020, 13'h004F, 13'h0050,
			13'h1FF7, 13'h1FF8, 13'h1FFD, 13'h1FFE, 13'h1FFF};
		ex = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h0, 4'h0, 4'h2, 4'h2, 4'h3, 4'h3};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			map_addr <= ad[i];
			repeat (2) @(posedge clk);
			chk("sel", ex[i], {sel_io, sel_p0, sel_vec, sel_rv});
		end
	endtask

	task t_freeze;
		@(posedge clk);
		map_addr <= 13'h0020;
		repeat (2) @(posedge clk);
		ce <= 0;
		map_addr <= 13'h0000;
		repeat (3) @(posedge clk);
		chk("frozen sel", 32'h4, {sel_io, sel_p0, sel_vec, sel_rv});
		ce <= 1;
		repeat (2) @(posedge clk);
		chk("thawed sel", 32'h8, {sel_io, sel_p0, sel_vec, sel_rv});
	endtask

	task t_vec;
		logic [7:0] hi;
		int n;
		for (int s = 0; s < 4; s++) begin
			hi = 8'hF8 + 8'(2 * s);
			@(posedge clk);
			vec_req <= 1;
			vec_src <= s[1:0];
			@(posedge clk);
			vec_req <= 0;
			n = 0;
			while (vec_valid !== 1'b1 && n < 20) begin
				@(posedge clk);
				n++;
			end
			chk("valid", 1, vec_valid);
			chk("vec", {hi ^ 8'h5A, (hi + 8'h01) ^ 8'h5A},
				vec_value);
		end
	endtask

	initial begin
		do_rst;
		t_reset_dirs;
		t_out_mode;
		t_in_mode;
		t_keep;
		t_refuse;
		t_decode;
		t_freeze;
		t_vec;
		close_out;
	end
endmodule
